// *** logic/cmd_parser.sv ***
`timescale 1ns/1ns
`default_nettype none
module cmd_parser #(
   parameter int depth_log2 = 3
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   output logic byte_ready,
   output logic cmd_valid,
   output cmd_parser_pkg::cmd_type cmd_out,
   input wire logic cmd_ready,
   output logic apply_valid,
   output cmd_parser_pkg::settings_type apply_out,
   input wire logic fault_trip,
   input wire logic err_clear,
   output logic [2:0] err_code,
   output logic hold_active,
   output logic out_disabled
);

   // ****************************************
   // Character and word decoding.
   // ****************************************
   typedef enum logic [10:0] {
      st_lead = 11'b000_0000_0001,
      st_key = 11'b000_0000_0010,
      st_gap = 11'b000_0000_0100,
      st_word = 11'b000_0000_1000,
      st_mant = 11'b000_0001_0000,
      st_exps = 11'b000_0010_0000,
      st_expd = 11'b000_0100_0000,
      st_unit = 11'b000_1000_0000,
      st_tail = 11'b001_0000_0000,
      st_sep = 11'b010_0000_0000,
      st_skip = 11'b100_0000_0000
   } state_type;

   function automatic logic [3:0] key_op(input logic [47:0] w);
      unique case (w)
         48'h0000_5653_4554: key_op = cmd_parser_pkg::op_vset;
         48'h0000_4953_4554: key_op = cmd_parser_pkg::op_iset;
         48'h004F_5653_4554: key_op = cmd_parser_pkg::op_ovset;
         48'h0000_0044_4C59: key_op = cmd_parser_pkg::op_dly;
         48'h0000_484F_4C44: key_op = cmd_parser_pkg::op_hold;
         48'h0000_0054_5247: key_op = cmd_parser_pkg::op_apply_deferred;
         48'h0000_004F_5554: key_op = cmd_parser_pkg::op_drive;
         48'h0000_0052_5354: key_op = cmd_parser_pkg::op_recover;
         48'h0000_4D41_534B: key_op = cmd_parser_pkg::op_suppress;
         48'h554E_4D41_534B: key_op = cmd_parser_pkg::op_event_allow;
         default: key_op = cmd_parser_pkg::op_none;
      endcase
   endfunction

   state_type st_reg, st_next;
   logic [47:0] word_reg;
   logic [2:0] wlen_reg;
   logic [13:0] mant_reg;
   logic [2:0] sig_reg;
   logic [7:0] exp_adj_reg;
   logic [6:0] exp_acc_reg;
   logic neg_reg, exp_neg_reg, have_dig_reg, exp_has_reg, frac_reg;
   logic [1:0] pidx_reg;
   cmd_parser_pkg::cmd_type rec_reg, rec_next;
   logic [2:0] err_reg;
   logic hold_reg, out_en_reg, trip_reg;

   wire logic is_lower = byte_data >= 8'h61 && byte_data <= 8'h7A;
   wire logic [7:0] up = is_lower ? (byte_data & 8'hDF) : byte_data;
   wire logic is_letter = up >= 8'h41 && up <= 8'h5A;
   wire logic is_digit = byte_data >= 8'h30 && byte_data <= 8'h39;
   wire logic [3:0] dval = byte_data[3:0];
   wire logic is_sp = byte_data == 8'h20;
   wire logic is_comma = byte_data == 8'h2C;
   wire logic is_semi = byte_data == 8'h3B;
   wire logic is_lf = byte_data == 8'h0A;
   wire logic is_sign = byte_data == 8'h2B || byte_data == 8'h2D;
   wire logic is_dot = byte_data == 8'h2E;
   wire logic is_e = up == 8'h45;
   wire logic num_start = is_digit || is_sign || is_dot;
   wire logic line_end = is_semi || is_lf;
   wire logic delim = is_sp || is_comma || line_end;
   wire logic fire = byte_valid && byte_ready;

   wire logic [3:0] op_w = key_op(word_reg);
   wire logic w_on = word_reg == 48'h0000_0000_4F4E;
   wire logic w_off = word_reg == 48'h0000_004F_4646;
   wire logic w_all = word_reg == 48'h0000_0041_4C4C;
   wire logic w_none = word_reg == 48'h0000_4E4F_4E45;
   wire logic [11:0] w_flags;
   genvar gi;
   generate
      for (gi = 0; gi < cmd_parser_pkg::status_count; gi++) begin : g_flag
         assign w_flags[gi] = word_reg == cmd_parser_pkg::status_words[gi];
      end
   endgenerate
   wire logic word_ok = w_on || w_off || w_all || w_none || (|w_flags);
   wire logic u_milli = word_reg == 48'h0000_0000_4D41 || word_reg == 48'h0000_0000_4D53 ||
      word_reg == 48'h0000_0000_4D56;
   wire logic u_base = word_reg == 48'h0000_0000_0041 || word_reg == 48'h0000_0000_0053 ||
      word_reg == 48'h0000_0000_0056;
   wire logic in_unit = st_reg == st_unit;
   wire logic unit_ok = !in_unit || u_milli || u_base;
   wire logic num_ok = (st_reg == st_expd) ? exp_has_reg : have_dig_reg;

   // Value in mantissa and power of ten, milli suffix lowers the power by three.
   wire logic [15:0] mant_ext = {2'b00, mant_reg};
   wire logic [15:0] mant_s = neg_reg ? 16'(-mant_ext) : mant_ext;
   wire logic [7:0] exp_part = exp_neg_reg ? 8'(-{1'b0, exp_acc_reg}) : {1'b0, exp_acc_reg};
   wire logic [7:0] exp_fin = 8'(exp_adj_reg + exp_part - ((in_unit && u_milli) ? cmd_parser_pkg::milli_shift : 8'h00));

   // ****************************************
   // Parser state machine.
   // ****************************************
   logic do_key, do_num, do_word, do_commit, do_release, do_clear;
   logic [2:0] err_hit;
   always_comb begin
      st_next = st_reg;
      do_key = 1'b0;
      do_num = 1'b0;
      do_word = 1'b0;
      do_commit = 1'b0;
      do_release = 1'b0;
      do_clear = 1'b0;
      err_hit = cmd_parser_pkg::err_none;
      if (fire) begin
         unique case (st_reg)
            st_lead: begin
               if (is_letter) st_next = st_key;
               else if (is_lf) do_release = 1'b1;
               else if (!is_sp && !is_semi) err_hit = cmd_parser_pkg::err_keyword;
            end
            st_key: begin
               if (is_letter) begin
                  if (wlen_reg == 3'(cmd_parser_pkg::word_chars)) err_hit = cmd_parser_pkg::err_keyword;
               end else if ((is_sp || line_end) && op_w == cmd_parser_pkg::op_none) begin
                  err_hit = cmd_parser_pkg::err_keyword;
               end else if (is_sp) begin
                  do_key = 1'b1;
                  st_next = st_gap;
               end else if (line_end) begin
                  do_key = 1'b1;
                  do_commit = 1'b1;
               end else err_hit = cmd_parser_pkg::err_separator;
            end
            st_gap, st_sep, st_tail: begin
               if (is_sp) st_next = st_reg;
               else if (st_reg != st_tail && is_letter) st_next = st_word;
               else if (st_reg != st_tail && num_start) st_next = st_mant;
               else if (st_reg == st_tail && is_comma) st_next = st_sep;
               else if (st_reg != st_sep && line_end) do_commit = 1'b1;
               else if (st_reg == st_tail && is_digit) err_hit = cmd_parser_pkg::err_number;
               else err_hit = cmd_parser_pkg::err_separator;
            end
            st_word: begin
               if (is_letter) begin
                  if (wlen_reg == 3'(cmd_parser_pkg::word_chars)) err_hit = cmd_parser_pkg::err_word;
               end else if (delim && !word_ok) err_hit = cmd_parser_pkg::err_word;
               else if (delim) do_word = 1'b1;
               else err_hit = cmd_parser_pkg::err_word;
            end
            st_mant: begin
               if (is_digit) st_next = st_mant;
               else if (is_dot && !frac_reg) st_next = st_mant;
               else if (is_e && have_dig_reg) st_next = st_exps;
               else if (is_letter && have_dig_reg) st_next = st_unit;
               else if (delim && have_dig_reg) do_num = 1'b1;
               else err_hit = cmd_parser_pkg::err_number;
            end
            st_exps: begin
               if (is_sign || is_digit) st_next = st_expd;
               else err_hit = cmd_parser_pkg::err_number;
            end
            st_expd: begin
               if (is_digit) st_next = st_expd;
               else if (is_letter && exp_has_reg) st_next = st_unit;
               else if (delim && num_ok) do_num = 1'b1;
               else err_hit = cmd_parser_pkg::err_number;
            end
            st_unit: begin
               if (is_letter && wlen_reg < 3'h2) st_next = st_unit;
               else if (delim && unit_ok) do_num = 1'b1;
               else err_hit = cmd_parser_pkg::err_number;
            end
            default: begin
               if (line_end) begin
                  st_next = st_lead;
                  do_clear = 1'b1;
                  do_release = is_lf;
               end
            end
         endcase
         if (do_num && pidx_reg == 2'h2) begin
            do_num = 1'b0;
            err_hit = cmd_parser_pkg::err_separator;
         end
         if ((do_num || do_word) && line_end) do_commit = 1'b1;
         else if (do_num || do_word) st_next = is_comma ? st_sep : st_tail;
         if (do_commit) begin
            st_next = st_lead;
            do_release = is_lf;
         end
         if (err_hit != cmd_parser_pkg::err_none) begin
            st_next = line_end ? st_lead : st_skip;
            do_commit = 1'b0;
            do_clear = 1'b1;
            do_release = is_lf;
         end
      end
   end

   always_comb begin
      rec_next = rec_reg;
      if (do_key) rec_next.op = op_w;
      if (do_num) begin
         rec_next.vals[pidx_reg[0]] = '{mant: mant_s, exp10: exp_fin};
         rec_next.state_on = mant_reg != 14'h0000;
         rec_next.nparam = 2'(pidx_reg + 2'h1);
      end
      if (do_word) begin
         if (w_on || w_off) rec_next.state_on = w_on;
         if (w_all) rec_next.flags = 12'hFFF;
         rec_next.flags = rec_next.flags | w_flags;
         rec_next.nparam = 2'(pidx_reg + 2'h1);
      end
   end

   // A comma counts a parameter whether or not spaces stand before it.
   wire logic next_param = ((do_num || do_word) && is_comma) || (st_reg == st_tail && st_next == st_sep);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= st_lead;
         rec_reg <= '0;
         pidx_reg <= 2'h0;
      end else begin
         st_reg <= st_next;
         rec_reg <= (do_commit || do_clear) ? '0 : rec_next;
         if (do_commit || do_clear) pidx_reg <= 2'h0;
         else if (next_param && pidx_reg != 2'h2) pidx_reg <= 2'(pidx_reg + 2'h1);
      end
   end

   // ****************************************
   // Token accumulators.
   // ****************************************
   wire logic start_word = fire && is_letter && st_next != st_skip &&
      (st_reg == st_lead || st_reg == st_gap || st_reg == st_sep || st_next == st_unit && st_reg != st_unit);
   wire logic start_num = fire && st_next == st_mant && st_reg != st_mant;
   wire logic sig_zero = mant_reg == 14'h0000 && dval == 4'h0;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         word_reg <= '0;
         wlen_reg <= 3'h0;
      end else if (start_word) begin
         word_reg <= {40'h00_0000_0000, up};
         wlen_reg <= 3'h1;
      end else if (fire && is_letter) begin
         word_reg <= {word_reg[39:0], up};
         wlen_reg <= 3'(wlen_reg + 3'h1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mant_reg <= 14'h0000;
         sig_reg <= 3'h0;
         exp_adj_reg <= 8'h00;
         exp_acc_reg <= 7'h00;
         {neg_reg, exp_neg_reg, have_dig_reg, exp_has_reg, frac_reg} <= 5'h00;
      end else if (start_num) begin
         mant_reg <= is_digit ? {10'h000, dval} : 14'h0000;
         sig_reg <= (is_digit && dval != 4'h0) ? 3'h1 : 3'h0;
         exp_adj_reg <= 8'h00;
         exp_acc_reg <= 7'h00;
         {neg_reg, exp_neg_reg, have_dig_reg, exp_has_reg, frac_reg} <=
            {byte_data == 8'h2D, 1'b0, is_digit, 1'b0, is_dot};
      end else if (fire && st_reg == st_mant && is_digit) begin
         have_dig_reg <= 1'b1;
         if (sig_zero) begin
            if (frac_reg) exp_adj_reg <= 8'(exp_adj_reg - 8'h01);
         end else if (sig_reg < 3'(cmd_parser_pkg::sig_figs)) begin
            mant_reg <= 14'(mant_reg * 14'd10 + {10'h000, dval});
            sig_reg <= 3'(sig_reg + 3'h1);
            if (frac_reg) exp_adj_reg <= 8'(exp_adj_reg - 8'h01);
         end else if (!frac_reg) exp_adj_reg <= 8'(exp_adj_reg + 8'h01);
      end else if (fire && st_reg == st_mant && is_dot) begin
         frac_reg <= 1'b1;
      end else if (fire && st_reg == st_exps) begin
         exp_neg_reg <= byte_data == 8'h2D;
         exp_has_reg <= is_digit;
         exp_acc_reg <= is_digit ? {3'h0, dval} : 7'h00;
      end else if (fire && st_reg == st_expd && is_digit) begin
         exp_has_reg <= 1'b1;
         if (exp_acc_reg < 7'd10) exp_acc_reg <= 7'(exp_acc_reg * 7'd10 + {3'h0, dval});
         else exp_acc_reg <= cmd_parser_pkg::exp_digit_max;
      end
   end

   // ****************************************
   // Command queue, released a line at a time.
   // ****************************************
   localparam int depth = 1 << depth_log2;
   cmd_parser_pkg::cmd_type mem [depth];
   logic [depth_log2:0] wr_ptr_reg, rel_ptr_reg, rd_ptr_reg;

   wire logic push = do_commit && rec_next.op != cmd_parser_pkg::op_none;
   wire logic [depth_log2:0] wr_ptr_next = push ? (depth_log2 + 1)'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
   wire logic [depth_log2:0] used = (depth_log2 + 1)'(wr_ptr_reg - rd_ptr_reg);
   wire logic head_valid = rd_ptr_reg != rel_ptr_reg;
   wire cmd_parser_pkg::cmd_type head = mem[rd_ptr_reg[depth_log2-1:0]];
   wire logic is_setting = head.op == cmd_parser_pkg::op_vset || head.op == cmd_parser_pkg::op_iset ||
      head.op == cmd_parser_pkg::op_ovset;
   wire logic pop = head_valid && (is_setting || cmd_ready);

   assign byte_ready = used < (depth_log2 + 1)'(depth);
   assign cmd_valid = head_valid && !is_setting;
   assign cmd_out = head;

   always_ff @(posedge clk) begin
      if (push) mem[wr_ptr_reg[depth_log2-1:0]] <= rec_next;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_reg <= '0;
         rel_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         if (do_release) rel_ptr_reg <= wr_ptr_next;
         if (pop) rd_ptr_reg <= (depth_log2 + 1)'(rd_ptr_reg + 1'b1);
      end
   end

   // ****************************************
   // Deferred settings.
   // ****************************************
   cmd_parser_pkg::settings_type pend_reg, apply_reg;
   logic apply_vld_reg;
   wire logic [1:0] slot = 2'(head.op - cmd_parser_pkg::op_vset);
   wire logic hold_after = (pop && head.op == cmd_parser_pkg::op_hold) ? head.state_on : hold_reg;
   wire logic out_en_after = (pop && head.op == cmd_parser_pkg::op_drive) ? head.state_on : out_en_reg;
   wire logic clears_trip = pop && (head.op == cmd_parser_pkg::op_recover ||
      head.op == cmd_parser_pkg::op_drive && head.state_on);
   wire logic defer = hold_reg || !out_en_reg || trip_reg;
   wire logic rel_hold = pop && head.op == cmd_parser_pkg::op_apply_deferred && out_en_reg && !trip_reg;
   wire logic rel_dis = clears_trip && out_en_after && !hold_after && !fault_trip;
   wire logic release_all = (rel_hold || rel_dis) && pend_reg.valid != 3'h0;
   wire logic apply_now = pop && is_setting && !defer;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_reg <= '0;
         apply_reg <= '0;
         apply_vld_reg <= 1'b0;
         hold_reg <= 1'b0;
         out_en_reg <= 1'b1;
         trip_reg <= 1'b0;
      end else begin
         hold_reg <= hold_after;
         out_en_reg <= out_en_after;
         if (fault_trip) trip_reg <= 1'b1;
         else if (clears_trip) trip_reg <= 1'b0;
         apply_vld_reg <= apply_now || release_all;
         if (release_all) begin
            apply_reg <= pend_reg;
            pend_reg <= '0;
         end else if (apply_now) begin
            apply_reg <= '0;
            apply_reg.valid[slot] <= 1'b1;
            apply_reg.vals[slot] <= head.vals[0];
         end else if (pop && is_setting) begin
            pend_reg.valid[slot] <= 1'b1;
            pend_reg.vals[slot] <= head.vals[0];
         end
      end
   end

   // ****************************************
   // Error record and status.
   // ****************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) err_reg <= cmd_parser_pkg::err_none;
      else if (err_hit != cmd_parser_pkg::err_none) err_reg <= err_hit;
      else if (err_clear) err_reg <= cmd_parser_pkg::err_none;
   end

   assign err_code = err_reg;
   assign apply_valid = apply_vld_reg;
   assign apply_out = apply_reg;
   assign hold_active = hold_reg;
   assign out_disabled = !out_en_reg || trip_reg;

endmodule
`default_nettype wire

// *** inc/cmd_parser_pkg.sv ***
// What this block does
// - Keywords and words match in any letter case.
// - Runs of spaces count as one separator.
// - Leading spaces ok; spaces inside numbers rejected.
// - One comma between parameters, spaces around allowed.
// - Status-name lists are comma separated items.
// - Current takes A or mA, default amps.
// - Time takes s or ms, default seconds.
// - Voltage takes V or mV, default volts.
// - State accepts 1/ON as true, 0/OFF false.
// - Status list accepts any defined name combination.
// - Numbers kept to four significant figures.
// - Optional sign, at most one decimal point.
// - Exponent after E or e, signed integer.
// - Semicolons split commands, spaces around allowed.
// - Line feed ends line and starts execution.
// - Settings after hold wait for apply command.
// - Settings while disabled wait for recover/drive on.
// - Commands execute strictly in arrival order.
package cmd_parser_pkg;

   // ****************************************
   // Encodings.
   // ****************************************
   localparam logic [3:0] op_none = 4'h0;
   localparam logic [3:0] op_vset = 4'h1;
   localparam logic [3:0] op_iset = 4'h2;
   localparam logic [3:0] op_ovset = 4'h3;
   localparam logic [3:0] op_dly = 4'h4;
   localparam logic [3:0] op_hold = 4'h5;
   localparam logic [3:0] op_apply_deferred = 4'h6;
   localparam logic [3:0] op_drive = 4'h7;
   localparam logic [3:0] op_recover = 4'h8;
   localparam logic [3:0] op_suppress = 4'h9;
   localparam logic [3:0] op_event_allow = 4'ha;

   localparam logic [2:0] err_none = 3'h0;
   localparam logic [2:0] err_keyword = 3'h1;
   localparam logic [2:0] err_separator = 3'h2;
   localparam logic [2:0] err_number = 3'h3;
   localparam logic [2:0] err_word = 3'h4;

   localparam int sig_figs = 4;
   localparam int word_chars = 6;
   localparam logic [6:0] exp_digit_max = 7'h63;
   localparam logic [7:0] milli_shift = 8'h03;
   localparam int status_count = 12;

   // Status names in flag bit order.
   localparam logic [47:0] status_words [status_count] = '{
      48'h0000_0000_4356, 48'h0000_0000_4343, 48'h0000_0000_4F56, 48'h0000_0000_4F54,
      48'h0000_0000_5344, 48'h0000_464F_4C44, 48'h0000_0045_5252, 48'h0000_0050_4F4E,
      48'h0000_0052_454D, 48'h0000_0041_4346, 48'h0000_004F_5046, 48'h0000_534E_5350};

   // ****************************************
   // Carriers.
   // ****************************************
   typedef struct packed {
      logic [15:0] mant;
      logic [7:0] exp10;
   } val_type;

   typedef struct packed {
      logic [3:0] op;
      logic [1:0] nparam;
      logic state_on;
      logic [11:0] flags;
      val_type [1:0] vals;
   } cmd_type;

   typedef struct packed {
      logic [2:0] valid;
      val_type [2:0] vals;
   } settings_type;

endpackage

// *** sim/cmd_parser_props.sv ***
`timescale 1ns/1ns
`default_nettype none
module cmd_parser_props (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   input wire logic byte_ready,
   input wire logic cmd_valid,
   input wire cmd_parser_pkg::cmd_type cmd_out,
   input wire logic cmd_ready,
   input wire logic apply_valid,
   input wire cmd_parser_pkg::settings_type apply_out,
   input wire logic fault_trip,
   input wire logic err_clear,
   input wire logic [2:0] err_code,
   input wire logic hold_active,
   input wire logic out_disabled
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_cmd_stable; cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_out); endproperty
   a_cmd_stable: assert property (p_cmd_stable) else $error("command changed before taken");
   property p_no_setting; cmd_valid |-> cmd_out.op > 4'h3; endproperty
   a_no_setting: assert property (p_no_setting) else $error("setting shown as command");
   property p_apply_any; apply_valid |-> apply_out.valid != 3'h0; endproperty
   a_apply_any: assert property (p_apply_any) else $error("empty apply");
   property p_hold_rel; apply_valid && hold_active |-> $past(cmd_valid && cmd_ready); endproperty
   a_hold_rel: assert property (p_hold_rel) else $error("apply during hold");
   property p_hold_set; cmd_valid && cmd_ready && cmd_out.op == 4'h5 && cmd_out.state_on |=> hold_active; endproperty
   a_hold_set: assert property (p_hold_set) else $error("hold not entered");
   property p_off_blocks; apply_valid |-> !out_disabled; endproperty
   a_off_blocks: assert property (p_off_blocks) else $error("apply while disabled");
   property p_drive_off; cmd_valid && cmd_ready && cmd_out.op == 4'h7 && !cmd_out.state_on |=> out_disabled; endproperty
   a_drive_off: assert property (p_drive_off) else $error("output not disabled");
   property p_err_sticky; err_code != 3'h0 && !err_clear |=> err_code != 3'h0; endproperty
   a_err_sticky: assert property (p_err_sticky) else $error("error lost");
   property p_err_range; err_code <= 3'h4; endproperty
   a_err_range: assert property (p_err_range) else $error("bad error code");
endmodule
bind cmd_parser cmd_parser_props i_props (.clk(clk), .rst_n(rst_n), .byte_valid(byte_valid),
   .byte_data(byte_data), .byte_ready(byte_ready), .cmd_valid(cmd_valid), .cmd_out(cmd_out),
   .cmd_ready(cmd_ready), .apply_valid(apply_valid), .apply_out(apply_out), .fault_trip(fault_trip),
   .err_clear(err_clear), .err_code(err_code), .hold_active(hold_active), .out_disabled(out_disabled));
`default_nettype wire

// *** sim/host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module host_model (
   input wire logic clk,
   input wire logic byte_ready,
   output logic byte_valid,
   output logic [7:0] byte_data
);
   initial begin
      byte_valid = 1'b0;
      byte_data = 8'h00;
   end
   // Sends whole keywords, spaces, semicolons and the closing line feed as given.
   task automatic send_line(input string s);
      int n;
      logic ok;
      for (int i = 0; i < s.len(); i++) begin
         byte_valid = 1'b1;
         byte_data = s[i];
         n = 0;
         ok = 1'b0;
         while (!ok && n < 500) begin
            ok = (byte_ready === 1'b1);
            n++;
            @(posedge clk);
            #1;
         end
      end
      byte_valid = 1'b0;
      byte_data = ~byte_data;
   endtask
endmodule
`default_nettype wire

// *** sim/ascii_supply_command_parser_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module ascii_supply_command_parser_tb;
   logic clk = 1'b0, rst_n = 1'b0, cmd_ready = 1'b0, err_clear = 1'b0, fault_trip = 1'b0;
   logic byte_valid, byte_ready, cmd_valid, apply_valid, hold_active, out_disabled;
   logic [7:0] byte_data;
   logic [2:0] err_code;
   cmd_parser_pkg::cmd_type cmd_out;
   cmd_parser_pkg::settings_type apply_out;
   cmd_parser_pkg::cmd_type cq[$];
   cmd_parser_pkg::settings_type aq[$];
   int n_mismatch = 0, checked = 0, cyc = 0, k;
   logic [15:0] lfsr = 16'h0013;
   string bad[3] = '{"MK FOLD\n", "VSET 1 5\n", "VSET 1,,2\n"};
   logic [2:0] bad_err[3] = '{3'h1, 3'h3, 3'h2};
   host_model i_host (.clk(clk), .byte_ready(byte_ready), .byte_valid(byte_valid), .byte_data(byte_data));
   cmd_parser i_dut (.clk(clk), .rst_n(rst_n), .byte_valid(byte_valid), .byte_data(byte_data),
      .byte_ready(byte_ready), .cmd_valid(cmd_valid), .cmd_out(cmd_out), .cmd_ready(cmd_ready),
      .apply_valid(apply_valid), .apply_out(apply_out), .fault_trip(fault_trip), .err_clear(err_clear),
      .err_code(err_code), .hold_active(hold_active), .out_disabled(out_disabled));
   always #4 clk = ~clk;
   function automatic logic [15:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction
   function automatic int milli(input real x);
      return $rtoi(x * 1000.0 + (x < 0.0 ? -0.5 : 0.5));
   endfunction
   function automatic real val(input cmd_parser_pkg::val_type v);
      real r = $itor($signed(v.mant));
      for (int i = 0; i < $signed(v.exp10); i++) r = r * 10.0;
      for (int i = 0; i > $signed(v.exp10); i--) r = r / 10.0;
      return r;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chkv(input cmd_parser_pkg::val_type v, input real e);
      chk(32'(milli(val(v))), 32'(milli(e)));
   endtask
   task automatic line(input string s, input int nc, input int na);
      int n = 0;
      cq.delete();
      aq.delete();
      @(posedge clk);
      #1;
      i_host.send_line(s);
      repeat (20) @(posedge clk);
      while ((cq.size() < nc || aq.size() < na) && n < 300) begin
         n++;
         @(posedge clk);
      end
      #1;
      chk(32'(cq.size()), 32'(nc));
      chk(32'(aq.size()), 32'(na));
      $display("test done, %0d checks so far", checked);
   endtask
   task automatic finish_test();
      $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cmd_valid === 1'b1 && cmd_ready === 1'b1) cq.push_back(cmd_out);
      if (apply_valid === 1'b1) aq.push_back(apply_out);
      if (cyc > 20000) begin
         n_mismatch++;
         finish_test();
      end else begin
         #1 cmd_ready = rnd() > 16'h5000;
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      #1 rst_n = 1'b1;
      line("vSeT 5\n", 0, 1);
      chk(32'(aq[0].valid), 32'h1);
      chkv(aq[0].vals[0], 5.0);
      line("ISET   250mA ;  OVSET -1.234E+1V\n", 0, 2);
      chkv(aq[0].vals[1], 0.25);
      chk(32'(aq[1].valid), 32'h4);
      chkv(aq[1].vals[2], -12.34);
      line("dly 1500ms\n", 1, 0);
      chkv(cq[0].vals[0], 1.5);
      line("HOLD ON;VSET 1.5;ISET 2\n", 1, 0);
      line($sformatf("%cRG\n", 8'h54), 1, 1);
      chk(32'(aq[0].valid), 32'h3);
      chkv(aq[0].vals[0], 1.5);
      chkv(aq[0].vals[1], 2.0);
      line("hold 0\n", 1, 0);
      chk(32'(hold_active), 32'h0);
      line("OUT OFF;VSET 3\n", 1, 0);
      chk(32'(out_disabled), 32'h1);
      line("out 1\n", 1, 1);
      chkv(aq[0].vals[0], 3.0);
      line("mask fold , err\n", 1, 0);
      chk(32'(cq[0].flags), 32'h0060);
      line("dly 1 , 2\n", 1, 0);
      chkv(cq[0].vals[1], 2.0);
      line($sformatf("%cNMASK all\n", 8'h55), 1, 0);
      chk(32'(cq[0].flags), 32'h0FFF);
      fault_trip = 1'b1;
      @(posedge clk);
      #1 fault_trip = 1'b0;
      line("VSET 4\n", 0, 0);
      chk(32'(out_disabled), 32'h1);
      line("rst\n", 1, 1);
      chkv(aq[0].vals[0], 4.0);
      chk(32'(out_disabled), 32'h0);
      for (int i = 0; i < 3; i++) begin
         line(bad[i], 0, 0);
         chk(32'(err_code), 32'(bad_err[i]));
         err_clear = 1'b1;
         @(posedge clk);
         #1 err_clear = 1'b0;
         chk(32'(err_code), 32'h0);
      end
      line("VSET 12.345\n", 0, 1);
      chkv(aq[0].vals[0], 12.34);
      repeat (4) begin
         k = int'(rnd() % 16'h03E8);
         line($sformatf("VSET  %0d.%0d\n", k / 10, k % 10), 0, 1);
         chkv(aq[0].vals[0], k / 10.0);
      end
      finish_test();
   end
endmodule
`default_nettype wire
